// *** logic/sfc_pkg.sv ***
// Notes on behaviour
// - Host keeps serial clock at most 20 MHz
// - Device accepts clock idling low or high
// - Idle low is mode 0, high mode 3
// - Device samples serial input on rising edge
// - Busy within 200 ns after select rises
// - Transfer or compare done within 250 us
// - Erase/program times 20, 14, 8, 12 ms
// - Select high before hardware reset released
// - Host drives reserved address bits as zero; sfc_host sends cmd_addr unmasked
// - Reserved bits extend the page address
// - Every byte takes exactly eight clocks
// - Host waits 20 ms after power up
// - Continuous read opcodes 68H and E8H
// - Page read opcodes 52H and D2H
// - Buffer read opcodes 54H and 56H
// - Status read 57H, no address bytes
// - Every command accepted in all modes
// - Four dummy bytes before continuous and page read data, one before buffer read data
package sfc_pkg;
	// Clock and timing figures
	localparam int CLK_KHZ       = 125000;
	localparam int SCK_MAX_MHZ   = 20;
	localparam int XFR_US        = 250;
	localparam int EP_MS         = 20;
	localparam int P_MS          = 14;
	localparam int PE_MS         = 8;
	localparam int BE_MS         = 12;
	localparam int RST_US        = 10;
	localparam int PWR_MS        = 20;
	localparam int CSS_NS        = 250;
	localparam int CSH_NS        = 250;
	localparam int CSHI_NS       = 250;
	localparam int BUSY_NS       = 200;
	// Cycle counts: least times round up, longest round down
	localparam int SCK_HALF_CYC  = (CLK_KHZ + 2 * SCK_MAX_MHZ * 1000 - 1)
		/ (2 * SCK_MAX_MHZ * 1000);
	localparam int XFR_CYC       = XFR_US * CLK_KHZ / 1000;
	localparam int EP_CYC        = EP_MS * CLK_KHZ;
	localparam int P_CYC         = P_MS * CLK_KHZ;
	localparam int PE_CYC        = PE_MS * CLK_KHZ;
	localparam int BE_CYC        = BE_MS * CLK_KHZ;
	localparam int RST_CYC       = (RST_US * CLK_KHZ + 999) / 1000;
	localparam int PWR_CYC       = PWR_MS * CLK_KHZ;
	localparam int CSS_CYC       = (CSS_NS * CLK_KHZ + 999999) / 1000000;
	localparam int CSH_CYC       = (CSH_NS * CLK_KHZ + 999999) / 1000000;
	localparam int CSHI_CYC      = (CSHI_NS * CLK_KHZ + 999999) / 1000000;
	localparam int BUSY_CYC      = BUSY_NS * CLK_KHZ / 1000000;
	// Field widths and counts
	localparam int TMR_W         = 22;
	localparam int PAGE_W        = 14;
	localparam int COL_W         = 10;
	localparam int LEN_W         = 16;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [3:0] ADDR_LAST = 4'h3;
	localparam logic [3:0] HDR_MAX  = 4'h8;
	localparam logic [3:0] HDR_STAT = 4'h1;
	localparam logic [3:0] HDR_BUF  = 4'h5;
	localparam logic [3:0] HDR_ADDR = 4'h4;
	// Opcodes
	localparam logic [7:0] OP_CAR_I  = 8'h68;
	localparam logic [7:0] OP_CAR_S  = 8'hE8;
	localparam logic [7:0] OP_PRD_I  = 8'h52;
	localparam logic [7:0] OP_PRD_S  = 8'hD2;
	localparam logic [7:0] OP_BRD1_I = 8'h54;
	localparam logic [7:0] OP_BRD2_I = 8'h56;
	localparam logic [7:0] OP_BRD1_S = 8'hD4;
	localparam logic [7:0] OP_BRD2_S = 8'hD6;
	localparam logic [7:0] OP_STAT_I = 8'h57;
	localparam logic [7:0] OP_STAT_S = 8'hD7;
	localparam logic [7:0] OP_BWR1   = 8'h84;
	localparam logic [7:0] OP_BWR2   = 8'h87;
	localparam logic [7:0] OP_MPG1   = 8'h82;
	localparam logic [7:0] OP_MPG2   = 8'h85;
	localparam logic [7:0] OP_EPG1   = 8'h83;
	localparam logic [7:0] OP_EPG2   = 8'h86;
	localparam logic [7:0] OP_PG1    = 8'h88;
	localparam logic [7:0] OP_PG2    = 8'h89;
	localparam logic [7:0] OP_PER    = 8'h81;
	localparam logic [7:0] OP_BER    = 8'h50;
	localparam logic [7:0] OP_XFR1   = 8'h53;
	localparam logic [7:0] OP_XFR2   = 8'h55;
	localparam logic [7:0] OP_CMP1   = 8'h60;
	localparam logic [7:0] OP_CMP2   = 8'h61;
	localparam logic [7:0] OP_APR1   = 8'h58;
	localparam logic [7:0] OP_APR2   = 8'h59;

	typedef enum logic [2:0] {
		TC_NONE = 3'b000,
		TC_XFR  = 3'b001,
		TC_EP   = 3'b010,
		TC_P    = 3'b011,
		TC_PE   = 3'b100,
		TC_BE   = 3'b101
	} sfc_tclass_t;

	// Status read opcodes
	function automatic logic is_status(input logic [7:0] op);
		return op == OP_STAT_I || op == OP_STAT_S;
	endfunction

	// Bytes before the data phase: opcode, address, dummies
	function automatic logic [3:0] hdr_len(input logic [7:0] op);
		unique case (op)
			OP_STAT_I, OP_STAT_S: return HDR_STAT;
			OP_CAR_I, OP_CAR_S, OP_PRD_I, OP_PRD_S: return HDR_MAX;
			OP_BRD1_I, OP_BRD2_I, OP_BRD1_S, OP_BRD2_S: return HDR_BUF;
			default: return HDR_ADDR;
		endcase
	endfunction

	// Commands that return data, in any clock mode
	function automatic logic is_read(input logic [7:0] op);
		return hdr_len(op) != HDR_ADDR;
	endfunction

	// Commands that carry data bytes in
	function automatic logic is_write(input logic [7:0] op);
		return op == OP_BWR1 || op == OP_BWR2 || op == OP_MPG1
			|| op == OP_MPG2;
	endfunction

	// Self-timed class of a command
	function automatic sfc_tclass_t tclass(input logic [7:0] op);
		unique case (op)
			OP_XFR1, OP_XFR2, OP_CMP1, OP_CMP2: return TC_XFR;
			OP_MPG1, OP_MPG2, OP_EPG1, OP_EPG2, OP_APR1, OP_APR2:
				return TC_EP;
			OP_PG1, OP_PG2: return TC_P;
			OP_PER: return TC_PE;
			OP_BER: return TC_BE;
			default: return TC_NONE;
		endcase
	endfunction
endpackage

// *** logic/sfc_link_if.sv ***
`timescale 1ns/1ps
interface sfc_link_if;
	logic cs_n;
	logic sck;
	logic si;
	logic so;
	logic so_oe;
	logic so_line;
	logic rdy;
	logic rst_n;
	// Serial output line with weak pull-up when released
	assign so_line = so_oe ? so : 1'b1;
	modport dev (input cs_n, sck, si, rst_n, output so, so_oe, rdy);
	modport host (output cs_n, sck, si, rst_n, input so_line, rdy);
endinterface

// *** logic/sfc_dev.sv ***
`timescale 1ns/1ps
module sfc_dev #(
	parameter int TRANSFER_COMPARE_TIME_CYC = sfc_pkg::XFR_CYC,
	parameter int T_EP_CYC  = sfc_pkg::EP_CYC,
	parameter int T_P_CYC   = sfc_pkg::P_CYC,
	parameter int T_PE_CYC  = sfc_pkg::PE_CYC,
	parameter int T_BE_CYC  = sfc_pkg::BE_CYC
) (
	input  wire logic                       clk,          // System clock
	input  wire logic                       nrst,         // Async reset
	sfc_link_if.dev                         link,         // Serial pins
	output logic [7:0]                      link_op,      // Last opcode
	output logic [sfc_pkg::PAGE_W-1:0]      link_page,    // Page address
	output logic [sfc_pkg::COL_W-1:0]       link_col,     // Byte address
	output logic                            link_rd_stb,  // Read byte taken
	input  wire logic [7:0]                 link_rd_data, // Byte to return
	output logic                            link_wr_tgl,  // New write byte
	output logic [7:0]                      link_wr_data, // Written byte
	output logic                            op_start,     // Op begins
	output logic [7:0]                      op_code,      // Op opcode
	output logic                            busy          // Op running
);
	import sfc_pkg::*;

	logic                    link_rst_n;
	logic                    frame_rst_n;
	logic [2:0]              bit_ff;
	logic [3:0]              byte_ff;
	logic [6:0]              sh_ff;
	logic [7:0]              op_ff;
	logic [23:0]             addr_ff;
	logic                    tgl_ff;
	logic [7:0]              out_ff;
	logic                    wr_tgl_ff;
	logic [7:0]              wr_data_ff;
	logic                    rdy_s1_ff;
	logic                    rdy_s2_ff;
	logic                    so_ff;
	logic                    so_oe_ff;
	logic                    cs_s1_ff;
	logic                    cs_s2_ff;
	logic                    cs_d_ff;
	logic                    tg_s1_ff;
	logic                    tg_s2_ff;
	logic                    seen_ff;
	logic                    busy_ff;
	logic [TMR_W-1:0]        tmr_ff;
	logic                    start_ff;
	logic [7:0]              code_ff;
	logic [7:0]              byte_in;
	logic                    byte_end;
	logic                    in_data;
	logic [3:0]              nxt_byte;
	logic [7:0]              op_now;
	logic                    load_out;
	logic [7:0]              nxt_out;
	logic                    cs_rise;
	sfc_tclass_t             cls;
	logic                    go;
	logic [TMR_W-1:0]        tload;

	// Hardware reset pin and frame boundaries
	assign link_rst_n  = nrst & link.rst_n;
	assign frame_rst_n = link_rst_n & ~link.cs_n;

	// Serial decode, link side
	assign byte_in  = {sh_ff, link.si};
	assign byte_end = bit_ff == BIT_LAST;
	assign in_data  = byte_ff >= hdr_len(op_ff);
	assign nxt_byte = (byte_ff == HDR_MAX) ? byte_ff : byte_ff + 4'h1;
	assign op_now   = (byte_ff == 4'h0) ? byte_in : op_ff;
	assign load_out = byte_end && is_read(op_now)
		&& nxt_byte >= hdr_len(op_now);
	assign nxt_out  = is_status(op_now) ? {rdy_s2_ff, 7'h00}
		: link_rd_data;

	// Bit and byte position, cleared by every deselect
	always_ff @(posedge link.sck or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			bit_ff  <= 3'h0;
			byte_ff <= 4'h0;
			sh_ff   <= 7'h00;
		end else begin
			bit_ff <= bit_ff + 3'h1;
			sh_ff  <= byte_in[6:0];
			if (byte_end)
				byte_ff <= nxt_byte;
		end
	end

	// Opcode and address capture
	always_ff @(posedge link.sck or negedge link_rst_n) begin
		if (!link_rst_n) begin
			op_ff   <= 8'h00;
			addr_ff <= 24'h00_0000;
			tgl_ff  <= 1'b0;
		end else if (byte_end) begin
			if (byte_ff == 4'h0)
				op_ff <= byte_in;
			if (byte_ff != 4'h0 && byte_ff <= ADDR_LAST
				&& !is_status(op_ff))
				addr_ff <= {addr_ff[15:0], byte_in};
			if (byte_ff == ADDR_LAST && !is_status(op_ff))
				tgl_ff <= ~tgl_ff;
		end
	end

	// Read data load and write data hand-off
	always_ff @(posedge link.sck or negedge link_rst_n) begin
		if (!link_rst_n) begin
			out_ff     <= 8'h00;
			wr_tgl_ff  <= 1'b0;
			wr_data_ff <= 8'h00;
		end else begin
			if (load_out)
				out_ff <= nxt_out;
			if (byte_end && is_write(op_ff) && in_data) begin
				wr_tgl_ff  <= ~wr_tgl_ff;
				wr_data_ff <= byte_in;
			end
		end
	end

	// Ready level into the link domain
	always_ff @(posedge link.sck or negedge link_rst_n) begin
		if (!link_rst_n) begin
			rdy_s1_ff <= 1'b0;
			rdy_s2_ff <= 1'b0;
		end else begin
			rdy_s1_ff <= ~busy_ff;
			rdy_s2_ff <= rdy_s1_ff;
		end
	end

	// Output shifts on falling edge, released on deselect
	always_ff @(negedge link.sck or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			so_ff    <= 1'b0;
			so_oe_ff <= 1'b0;
		end else begin
			so_oe_ff <= is_read(op_ff) && in_data;
			so_ff    <= out_ff[3'(BIT_LAST - bit_ff)];
		end
	end

	// Deselect edge and address-complete event into clk domain
	always_ff @(posedge clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			cs_s1_ff <= 1'b1;
			cs_s2_ff <= 1'b1;
			cs_d_ff  <= 1'b1;
			tg_s1_ff <= 1'b0;
			tg_s2_ff <= 1'b0;
		end else begin
			cs_s1_ff <= link.cs_n;
			cs_s2_ff <= cs_s1_ff;
			cs_d_ff  <= cs_s2_ff;
			tg_s1_ff <= tgl_ff;
			tg_s2_ff <= tg_s1_ff;
		end
	end

	// Start decision; opcode is quiet while deselected
	assign cs_rise = cs_s2_ff & ~cs_d_ff;
	assign cls     = tclass(op_ff);
	assign go      = cs_rise && (tg_s2_ff != seen_ff) && !busy_ff
		&& cls != TC_NONE;
	assign tload   = (cls == TC_XFR) ? TMR_W'(TRANSFER_COMPARE_TIME_CYC - 1)
		: (cls == TC_EP) ? TMR_W'(T_EP_CYC - 1)
		: (cls == TC_P) ? TMR_W'(T_P_CYC - 1)
		: (cls == TC_PE) ? TMR_W'(T_PE_CYC - 1)
		: TMR_W'(T_BE_CYC - 1);

	// Self-timed operation counter
	always_ff @(posedge clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			seen_ff  <= 1'b0;
			busy_ff  <= 1'b0;
			tmr_ff   <= '0;
			start_ff <= 1'b0;
			code_ff  <= 8'h00;
		end else begin
			start_ff <= go;
			if (cs_rise)
				seen_ff <= tg_s2_ff;
			if (go) begin
				busy_ff <= 1'b1;
				tmr_ff  <= tload;
				code_ff <= op_ff;
			end else if (busy_ff) begin
				if (tmr_ff == '0)
					busy_ff <= 1'b0;
				else
					tmr_ff <= tmr_ff - 1'b1;
			end
		end
	end

	// Pin and user outputs
	assign link.so      = so_ff;
	assign link.so_oe   = so_oe_ff;
	assign link.rdy     = ~busy_ff;
	assign link_op      = op_ff;
	assign link_page    = addr_ff[23:COL_W];
	assign link_col     = addr_ff[COL_W-1:0];
	assign link_rd_stb  = load_out;
	assign link_wr_tgl  = wr_tgl_ff;
	assign link_wr_data = wr_data_ff;
	assign op_start     = start_ff;
	assign op_code      = code_ff;
	assign busy         = busy_ff;
endmodule

// *** logic/sfc_host.sv ***
`timescale 1ns/1ps
module sfc_host #(
	parameter int T_PWR_CYC = sfc_pkg::PWR_CYC
) (
	input  wire logic                       clk,        // System clock
	input  wire logic                       nrst,       // Async reset
	sfc_link_if.host                        link,       // Serial pins
	input  wire logic                       idle_high,  // Clock idle level
	input  wire logic                       cmd_valid,  // Command offered
	output logic                            cmd_ready,  // Command taken
	input  wire logic [7:0]                 cmd_op,     // Opcode
	input  wire logic [23:0]                cmd_addr,   // Address bytes
	input  wire logic [sfc_pkg::LEN_W-1:0]  cmd_len,    // Data bytes
	input  wire logic [7:0]                 wr_data,    // Byte to send
	output logic                            wr_take,    // Byte consumed
	output logic [7:0]                      rd_data,    // Byte received
	output logic                            rd_valid,   // Byte strobe
	output logic                            link_ready  // Device ready
);
	import sfc_pkg::*;

	typedef enum logic [2:0] {
		H_RST   = 3'b000,
		H_PWR   = 3'b001,
		H_IDLE  = 3'b010,
		H_SETUP = 3'b011,
		H_LOW   = 3'b100,
		H_HIGH  = 3'b101,
		H_HOLD  = 3'b110,
		H_DESEL = 3'b111
	} sfc_hst_t;

	sfc_hst_t                st_ff;
	logic [TMR_W-1:0]        cnt_ff;
	logic [7:0]              op_ff;
	logic [23:0]             addr_ff;
	logic [LEN_W:0]          tot_ff;
	logic [LEN_W:0]          byte_ff;
	logic [2:0]              bit_ff;
	logic [7:0]              tx_ff;
	logic [7:0]              rx_ff;
	logic                    si_ff;
	logic                    sck_ff;
	logic                    cs_ff;
	logic                    rpin_ff;
	logic                    rdy_s1_ff;
	logic                    rdy_s2_ff;
	logic                    so_s1_ff;
	logic                    so_s2_ff;
	logic [7:0]              rd_data_ff;
	logic                    rd_valid_ff;
	logic                    cnt_end;
	logic                    last_bit;
	logic [LEN_W:0]          nxt_idx;
	logic                    nxt_data;
	logic [7:0]              nxt_tx;
	logic [7:0]              rx_in;
	logic                    accept;

	// Next byte to shift out: opcode, address, dummies, data
	assign cnt_end  = cnt_ff == '0;
	assign last_bit = bit_ff == BIT_LAST && byte_ff == tot_ff - 1'b1;
	assign nxt_idx  = byte_ff + 1'b1;
	assign nxt_data = nxt_idx >= (LEN_W+1)'(hdr_len(op_ff));
	assign nxt_tx   = is_status(op_ff) ? 8'h00
		: (nxt_idx == 17'h0_0001) ? addr_ff[23:16]
		: (nxt_idx == 17'h0_0002) ? addr_ff[15:8]
		: (nxt_idx == 17'h0_0003) ? addr_ff[7:0]
		: (nxt_data && is_write(op_ff)) ? wr_data
		: 8'h00;
	assign rx_in    = {rx_ff[6:0], so_s2_ff};
	assign accept   = cmd_valid && cmd_ready;
	assign wr_take  = st_ff == H_HIGH && cnt_end && bit_ff == BIT_LAST
		&& !last_bit && nxt_data && is_write(op_ff);
	assign cmd_ready = st_ff == H_IDLE
		&& (rdy_s2_ff || is_status(cmd_op));

	// Pin synchronisers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdy_s1_ff <= 1'b0;
			rdy_s2_ff <= 1'b0;
			so_s1_ff  <= 1'b1;
			so_s2_ff  <= 1'b1;
		end else begin
			rdy_s1_ff <= link.rdy;
			rdy_s2_ff <= rdy_s1_ff;
			so_s1_ff  <= link.so_line;
			so_s2_ff  <= so_s1_ff;
		end
	end

	// Sequencer: reset, power wait, frame, clock divider
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_ff       <= H_RST;
			cnt_ff      <= TMR_W'(RST_CYC - 1);
			op_ff       <= 8'h00;
			addr_ff     <= 24'h00_0000;
			tot_ff      <= '0;
			byte_ff     <= '0;
			bit_ff      <= 3'h0;
			tx_ff       <= 8'h00;
			rx_ff       <= 8'h00;
			si_ff       <= 1'b0;
			sck_ff      <= 1'b0;
			cs_ff       <= 1'b1;
			rpin_ff     <= 1'b0;
			rd_data_ff  <= 8'h00;
			rd_valid_ff <= 1'b0;
		end else begin
			rd_valid_ff <= 1'b0;
			if (!cnt_end)
				cnt_ff <= cnt_ff - 1'b1;
			unique case (st_ff)
				H_RST: begin
					if (cnt_end) begin
						rpin_ff <= 1'b1;
						cnt_ff  <= TMR_W'(T_PWR_CYC - 1);
						st_ff   <= H_PWR;
					end
				end
				H_PWR: begin
					sck_ff <= idle_high;
					if (cnt_end)
						st_ff <= H_IDLE;
				end
				H_IDLE: begin
					sck_ff <= idle_high;
					if (accept) begin
						op_ff   <= cmd_op;
						addr_ff <= cmd_addr;
						tot_ff  <= {1'b0, cmd_len}
							+ (LEN_W+1)'(hdr_len(cmd_op));
						byte_ff <= '0;
						bit_ff  <= 3'h0;
						tx_ff   <= cmd_op;
						si_ff   <= cmd_op[7];
						cs_ff   <= 1'b0;
						cnt_ff  <= TMR_W'(CSS_CYC - 1);
						st_ff   <= H_SETUP;
					end
				end
				H_SETUP: begin
					if (cnt_end) begin
						sck_ff <= 1'b0;
						cnt_ff <= TMR_W'(SCK_HALF_CYC - 1);
						st_ff  <= H_LOW;
					end
				end
				H_LOW: begin
					if (cnt_end) begin
						sck_ff <= 1'b1;
						rx_ff  <= rx_in;
						if (bit_ff == BIT_LAST && is_read(op_ff)
							&& byte_ff >= (LEN_W+1)'(hdr_len(op_ff))) begin
							rd_data_ff  <= rx_in;
							rd_valid_ff <= 1'b1;
						end
						cnt_ff <= TMR_W'(SCK_HALF_CYC - 1);
						st_ff  <= H_HIGH;
					end
				end
				H_HIGH: begin
					if (cnt_end && last_bit) begin
						sck_ff <= idle_high;
						cnt_ff <= TMR_W'(CSH_CYC - 1);
						st_ff  <= H_HOLD;
					end else if (cnt_end) begin
						sck_ff <= 1'b0;
						bit_ff <= bit_ff + 3'h1;
						if (bit_ff == BIT_LAST) begin
							byte_ff <= nxt_idx;
							tx_ff   <= nxt_tx;
							si_ff   <= nxt_tx[7];
						end else begin
							tx_ff <= {tx_ff[6:0], 1'b0};
							si_ff <= tx_ff[6];
						end
						cnt_ff <= TMR_W'(SCK_HALF_CYC - 1);
						st_ff  <= H_LOW;
					end
				end
				H_HOLD: begin
					if (cnt_end) begin
						cs_ff  <= 1'b1;
						cnt_ff <= TMR_W'(CSHI_CYC - 1);
						st_ff  <= H_DESEL;
					end
				end
				H_DESEL: begin
					sck_ff <= idle_high;
					if (cnt_end)
						st_ff <= H_IDLE;
				end
			endcase
		end
	end

	// Pin and user outputs
	assign link.cs_n  = cs_ff;
	assign link.sck   = sck_ff;
	assign link.si    = si_ff;
	assign link.rst_n = rpin_ff;
	assign rd_data    = rd_data_ff;
	assign rd_valid   = rd_valid_ff;
	assign link_ready = st_ff == H_IDLE && rdy_s2_ff;
endmodule

// *** tb/sfc_link_sva.sv ***
`timescale 1ns/1ps
module sfc_link_sva (
	input wire logic clk,   // System clock
	input wire logic nrst,  // Async reset
	input wire logic cs_n,  // Select
	input wire logic sck,   // Link clock
	input wire logic si,    // Host data
	input wire logic so,    // Device data
	input wire logic so_oe, // Device drives so
	input wire logic rdy,   // Ready, low busy
	input wire logic rst_n  // Reset pin
);
	import sfc_pkg::*;
	logic       sck_q_ff, idle_ff, nxt_idle, sck_rise, st_op;
	logic [3:0] half_ff, nxt_half;
	logic [2:0] bit_ff, nxt_bit;
	logic [5:0] tot_ff, nxt_tot;
	logic [7:0] op_ff, nxt_op;
	logic [4:0] desel_ff, nxt_desel;
	// Link activity seen from the system clock
	assign sck_rise  = !cs_n && sck && !sck_q_ff;
	assign nxt_half  = (sck != sck_q_ff) ? 4'h1
		: half_ff + {3'h0, half_ff != 4'hf};
	assign nxt_idle  = cs_n ? sck : idle_ff;
	assign nxt_bit   = cs_n ? 3'h0 : bit_ff + {2'h0, sck_rise};
	assign nxt_tot   = cs_n ? 6'h00
		: tot_ff + {5'h00, sck_rise && tot_ff != 6'h3f};
	assign nxt_op    = (sck_rise && tot_ff < 6'h08) ? {op_ff[6:0], si} : op_ff;
	assign nxt_desel = !cs_n ? 5'h00 : desel_ff + {4'h0, desel_ff != 5'h1f};
	assign st_op     = op_ff inside {OP_XFR1, OP_XFR2, OP_CMP1, OP_CMP2,
		OP_MPG1, OP_MPG2, OP_EPG1, OP_EPG2, OP_APR1, OP_APR2, OP_PG1,
		OP_PG2, OP_PER, OP_BER};
	// Helper registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sck_q_ff <= 1'b0;
			idle_ff  <= 1'b0;
			half_ff  <= 4'h0;
			bit_ff   <= 3'h0;
			tot_ff   <= 6'h00;
			op_ff    <= 8'h00;
			desel_ff <= 5'h00;
		end else begin
			sck_q_ff <= sck;
			idle_ff  <= nxt_idle;
			half_ff  <= nxt_half;
			bit_ff   <= nxt_bit;
			tot_ff   <= nxt_tot;
			op_ff    <= nxt_op;
			desel_ff <= nxt_desel;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// Serial output and busy behaviour
	property p_so_release; cs_n |-> !so_oe; endproperty
	a_so_release: assert property (p_so_release)
		else $error("so driven while deselected");
	property p_busy_cause; $fell(rdy) |-> cs_n && desel_ff <= BUSY_CYC;
	endproperty
	a_busy_cause: assert property (p_busy_cause)
		else $error("busy not caused by deselect");
	property p_busy_start;
		$rose(cs_n) && rdy && st_op && tot_ff >= 6'h20 |-> ##[1:25] !rdy;
	endproperty
	a_busy_start: assert property (p_busy_start)
		else $error("busy late after deselect");
	property p_so_launch; so_oe && $past(so_oe) && $changed(so) |-> !sck;
	endproperty
	a_so_launch: assert property (p_so_launch)
		else $error("so changed while sck high");
	// Link framing
	property p_sck_half; !cs_n && sck != sck_q_ff |-> half_ff >= SCK_HALF_CYC;
	endproperty
	a_sck_half: assert property (p_sck_half)
		else $error("sck half period too short");
	property p_byte_frame; $rose(cs_n) |-> bit_ff == 3'h0; endproperty
	a_byte_frame: assert property (p_byte_frame)
		else $error("frame not whole bytes");
	property p_idle_level; $rose(cs_n) |-> sck == idle_ff; endproperty
	a_idle_level: assert property (p_idle_level)
		else $error("sck idle level changed in frame");
	property p_reset_order; $rose(rst_n) |-> cs_n; endproperty
	a_reset_order: assert property (p_reset_order)
		else $error("reset released while selected");
endmodule

// *** tb/serial_flash_command_timing_tb.sv ***
`timescale 1ns/1ps
module serial_flash_command_timing_tb;
	import sfc_pkg::*;
	localparam int TRANSFER_COMPARE_TIME = 300;
	localparam int T_EP  = 500;
	localparam int T_P   = 450;
	localparam int T_PE  = 350;
	localparam int T_BE  = 400;
	logic              clk, nrst, idle_high, cmd_valid, cmd_ready, wr_take;
	logic              rd_valid, link_ready, link_rd_stb, link_wr_tgl, tgl_q;
	logic              rdy_q;
	logic [7:0]        cmd_op, wr_data, rd_data, link_op, link_rd_data;
	logic [7:0]        link_wr_data, op_code, rd_ptr;
	logic [23:0]       cmd_addr;
	logic [LEN_W-1:0]  cmd_len;
	logic [PAGE_W-1:0] link_page;
	logic [COL_W-1:0]  link_col;
	logic [7:0]        rdq[$], wrq[$], wr_bytes[4];
	int                miscompares, tests_run, rises, wr_idx, lat, dur, cnt;
	int                starts;
	logic              dev_busy, op_start_w;
	// System clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	sfc_link_if sfc_link_if_i ();
	sfc_host #(.T_PWR_CYC(50)) sfc_host_i (.clk, .nrst, .link(sfc_link_if_i),
		.idle_high, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_len,
		.wr_data, .wr_take, .rd_data, .rd_valid, .link_ready);
	sfc_dev #(.TRANSFER_COMPARE_TIME_CYC(TRANSFER_COMPARE_TIME), .T_EP_CYC(T_EP), .T_P_CYC(T_P),
		.T_PE_CYC(T_PE), .T_BE_CYC(T_BE)) sfc_dev_i (.clk, .nrst,
		.link(sfc_link_if_i), .link_op, .link_page, .link_col, .link_rd_stb,
		.link_rd_data, .link_wr_tgl, .link_wr_data, .op_start(op_start_w),
		.op_code, .busy(dev_busy));
	sfc_link_sva sfc_link_sva_i (.clk, .nrst, .cs_n(sfc_link_if_i.cs_n),
		.sck(sfc_link_if_i.sck), .si(sfc_link_if_i.si), .so(sfc_link_if_i.so),
		.so_oe(sfc_link_if_i.so_oe), .rdy(sfc_link_if_i.rdy),
		.rst_n(sfc_link_if_i.rst_n));
	// Data sources for both ends
	assign wr_data = wr_bytes[wr_idx[1:0]];
	assign link_rd_data = 8'hc3 ^ rd_ptr;
	always @(posedge sfc_link_if_i.sck or posedge sfc_link_if_i.cs_n) begin
		if (sfc_link_if_i.cs_n) rd_ptr <= 8'h00;
		else if (link_rd_stb) rd_ptr <= rd_ptr + 8'h01;
	end
	// Bit count per frame
	always @(negedge sfc_link_if_i.cs_n) rises = 0;
	always @(posedge sfc_link_if_i.sck) if (!sfc_link_if_i.cs_n) rises++;
	// Byte capture and busy timing
	always @(posedge clk) begin
		if (wr_take === 1'b1) wr_idx <= wr_idx + 1;
		if (rd_valid === 1'b1) rdq.push_back(rd_data);
		if (op_start_w === 1'b1) starts <= starts + 1;
		if (link_wr_tgl !== tgl_q) wrq.push_back(link_wr_data);
		tgl_q <= link_wr_tgl;
		rdy_q <= sfc_link_if_i.rdy;
		cnt <= sfc_link_if_i.cs_n ? cnt + 1 : 0;
		if (rdy_q && !sfc_link_if_i.rdy) lat <= cnt;
		if (!sfc_link_if_i.rdy) dur <= rdy_q ? 0 : dur + 1;
	end
	task automatic chk(input string what, input logic [31:0] exp, got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	// One whole command through the host port
	task automatic frame(input logic [7:0] op, input logic [23:0] a,
		input logic [15:0] len);
		int n;
		n = 0;
		rdq.delete();
		wrq.delete();
		wr_idx = 0;
		@(negedge clk);
		cmd_op = op;
		cmd_addr = a;
		cmd_len = len;
		cmd_valid = 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (cmd_ready !== 1'b1 && n < 5000);
		@(negedge clk);
		cmd_valid = 1'b0;
		chk("frame taken", 1, n < 5000);
		while (sfc_link_if_i.cs_n !== 1'b1 && n < 10000) begin
			@(posedge clk);
			n++;
		end
		chk("frame done", 1, n < 10000);
	endtask
	task automatic t_status();
		logic [7:0] ops[2] = '{OP_STAT_I, OP_STAT_S};
		for (int m = 0; m < 2; m++) begin
			@(negedge clk);
			idle_high = m[0];
			foreach (ops[i]) begin
				frame(ops[i], 24'h00_0000, 16'h0001);
				chk("status op", ops[i], link_op);
				chk("status bits", 16, rises);
				chk("status byte", 8'h80, rdq[0]);
			end
		end
		$display("test status done");
	endtask
	task automatic t_reads();
		logic [7:0] ops[6] = '{OP_CAR_I, OP_CAR_S, OP_PRD_I, OP_PRD_S,
			OP_BRD1_I, OP_BRD2_I};
		logic [23:0] a = 24'h35_a6c3;
		for (int m = 0; m < 2; m++) begin
			@(negedge clk);
			idle_high = m[0];
			foreach (ops[i]) begin
				frame(ops[i], a, 16'h0002);
				chk("read bits", (i < 4 ? 10 : 7) * 8, rises);
				chk("read count", 2, rdq.size());
				for (int k = 0; k < 2; k++) begin
					chk("read byte", 8'hc3 ^ k, rdq[k]);
				end
				chk("column", a[9:0], link_col);
				if (i < 4) chk("page", a[23:10], link_page);
			end
		end
		$display("test reads done");
	endtask
	task automatic t_write();
		@(negedge clk);
		wr_bytes = '{8'ha5, 8'h5a, 8'h0f, 8'hf0};
		frame(OP_BWR1, 24'h00_0155, 16'h0003);
		chk("write bits", 56, rises);
		chk("write count", 3, wrq.size());
		for (int k = 0; k < 3; k++) chk("write byte", wr_bytes[k], wrq[k]);
		chk("write col", 10'h155, link_col);
		$display("test write done");
	endtask
	task automatic t_busy();
		logic [7:0] ops[6] = '{OP_XFR1, OP_EPG1, OP_PG1, OP_PER, OP_BER,
			OP_CMP2};
		int tt[6] = '{TRANSFER_COMPARE_TIME, T_EP, T_P, T_PE, T_BE, TRANSFER_COMPARE_TIME};
		int n;
		foreach (ops[i]) begin
			lat = 99;
			dur = 0;
			frame(ops[i], 24'h12_3400, 16'h0000);
			n = 0;
			while (sfc_link_if_i.rdy !== 1'b0 && n < 40) begin
				@(posedge clk);
				n++;
			end
			chk("busy out", 1, dev_busy);
			if (i == 1) begin
				frame(OP_STAT_S, 24'h00_0000, 16'h0001);
				chk("busy status", 8'h00, rdq[0]);
				repeat (40) @(posedge clk);
				chk("host waits", 0, link_ready);
			end
			while (sfc_link_if_i.rdy !== 1'b1 && n < 2000) begin
				@(posedge clk);
				n++;
			end
			repeat (2) @(posedge clk);
			chk("busy delay", 1, lat <= BUSY_CYC);
			chk("busy span", 1, dur < tt[i] && dur + 4 >= tt[i]);
			chk("op code", ops[i], op_code);
			chk("op page", 14'h048d, link_page);
			chk("op starts", i + 1, starts);
		end
		$display("test busy done");
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Hang guard
	initial begin
		repeat (60000) @(posedge clk);
		miscompares++;
		stop_test();
	end
	// Main sequence
	initial begin
		nrst = 1'b0;
		idle_high = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = 8'h00;
		cmd_addr = 24'h00_0000;
		cmd_len = 16'h0000;
		wr_bytes = '{8'h00, 8'h00, 8'h00, 8'h00};
		wr_idx = 0;
		repeat (10) @(posedge clk);
		@(negedge clk);
		nrst = 1'b1;
		t_status();
		t_reads();
		t_write();
		t_busy();
		stop_test();
	end
endmodule
